// [verilog/asp_pkg.sv]
/*
 * Constants and types shared by the serial port core and its buffer.
 * Assumes a single system clock; the baud timer sits outside this block.
 */
package asp_pkg;
    localparam logic [7:0] ASP_CTRL_ADDR  = 8'h98;
    localparam logic [7:0] ASP_DATA_ADDR  = 8'h99;
    localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
    localparam logic [7:0] ASP_RDATA_NONE = 8'h00;
    localparam int         ASP_MODE_BIT   = 7;
    localparam int         ASP_SPARE_BIT  = 6;
    localparam int         ASP_MCE_BIT    = 5;
    localparam int         ASP_REN_BIT    = 4;
    localparam int         ASP_TB8_BIT    = 3;
    localparam int         ASP_RB8_BIT    = 2;
    localparam int         ASP_TI_BIT     = 1;
    localparam int         ASP_RI_BIT     = 0;
    localparam logic [3:0] ASP_LAST_DATA  = 4'h7;
    localparam logic [7:0] ASP_TMR_TOP    = 8'hFF;
    localparam logic [1:0] ASP_BUF_DEPTH  = 2'h2;

    typedef enum logic [2:0]
    {
        ASP_IDLE  = 3'h0,
        ASP_START = 3'h1,
        ASP_DATA  = 3'h2,
        ASP_NINTH = 3'h3,
        ASP_STOP  = 3'h4
    } asp_bit_state_type;

    typedef struct packed
    {
        logic [7:0]        ctrl;
        logic [7:0]        rx_latch;
        logic [7:0]        rdata;
        logic              sync1;
        logic              sync2;
        logic              rx_prev;
        logic              tx_phase;
        asp_bit_state_type tx_st;
        logic [7:0]        tx_sh;
        logic [3:0]        tx_cnt;
        logic              tx_out;
        logic [7:0]        rx_tmr;
        logic              rx_phase;
        asp_bit_state_type rx_st;
        logic [7:0]        rx_sh;
        logic [3:0]        rx_cnt;
        logic              rx_ninth;
    } asp_core_type;

    // Synchroniser and edge flops start at the idle line level, so reset makes no false start.
    localparam asp_core_type ASP_CORE_RESET = '{
        ctrl:    ASP_CTRL_RESET,
        sync1:   1'b1,
        sync2:   1'b1,
        rx_prev: 1'b1,
        tx_out:  1'b1,
        tx_st:   ASP_IDLE,
        rx_st:   ASP_IDLE,
        default: '0
    };
endpackage

// [verilog/asp_stream_if.sv]
/*
 * Byte stream with valid and ready between the port core and its buffer.
 * Assumes both ends run on the same clock.
 */
interface asp_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [verilog/asp_fifo2.sv]
/*
 * Two-entry byte buffer with valid and ready on both sides.
 * Assumes the source holds valid and data until ready is seen.
 */
module asp_fifo2
    import asp_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Filling and draining sides.
    asp_stream_if.snk in_s,
    asp_stream_if.src out_s
);
    typedef struct packed
    {
        logic [1:0][7:0] mem;
        logic            wp;
        logic            rp;
        logic [1:0]      cnt;
    } asp_fifo_type;

    asp_fifo_type st_r;
    asp_fifo_type st_nxt;
    logic         push;
    logic         pop;

    assign in_s.ready  = (st_r.cnt != ASP_BUF_DEPTH);
    assign out_s.valid = (st_r.cnt != 2'h0);
    assign out_s.data  = st_r.mem[st_r.rp];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_s.data;
            st_nxt.wp           = ~st_r.wp;
        end
        if (pop)
        begin
            st_nxt.rp = ~st_r.rp;
        end
        if (push && !pop)
        begin
            st_nxt.cnt = st_r.cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            st_nxt.cnt = st_r.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// [verilog/asp_serial_port.sv]
/*
 * Full-duplex asynchronous serial port with 8-bit and 9-bit frames,
 * a control register and a shared data location on the register port.
 * Assumes an external timer gives its clock tick, its overflow and its
 * reload byte on the system clock; the interrupt enable lives outside.
 */
// What this block does
// - Control bit 7 picks 8-bit or 9-bit frame format.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bit times.
// - 9-bit frame: start, eight data bits, ninth bit, stop; eleven bit times.
// - Drive output pin, take input pin, both shifting LSB first.
// - Writing the data location queues that byte for sending; a write while the buffer is full is lost.
// - Transmit-done flag sets as the stop-bit time begins.
// - Reception happens only while receive enable is 1.
// - 8-bit: load byte, stop bit into bit 2, if flag clear and, with bit 5 set, stop ok.
// - Rejected character leaves buffer, ninth-bit field and flag alone.
// - On overrun the buffer keeps the first byte; later bits are lost.
// - 9-bit: sent ninth bit equals control bit 3.
// - 9-bit: store ninth bit; load if flag clear and filter passes.
// - Interrupt request when enabled and either done flag is set.
// - Receive-done flag sets when the stop bit of an accepted byte samples.
// - Hardware never clears the done flags; software does.
// - Control bit 6 always reads 1; writes are ignored.
// - Bit rate comes from overflows of an auto-reload timer.
// - Transmit and receive rates are overflows halved; receive timer separate.
// - Receive timer reloads when a start bit is seen.
// - Data writes go to transmit, reads give only the receive buffer.
module asp_serial_port
    import asp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port.
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    output logic            tx_buf_ready,
    // Baud timer.
    input  wire logic       timer_clk_tick,
    input  wire logic       timer_ovf,
    input  wire logic [7:0] baud_timer_reload_byte,
    // Interrupt.
    input  wire logic       irq_enable,
    output logic            irq_req,
    // Serial pins.
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin
);
    ////////////////////////////////////////////////////////////////////////
    asp_core_type st_r;
    asp_core_type st_nxt;
    logic         tx_tick;
    logic         rx_ovf;
    logic         rx_sample;
    logic         mode9;
    logic         ctrl_wr;
    logic         rx_bit9;
    logic         rx_accept;

    asp_stream_if wr_s ();
    asp_stream_if rd_s ();

    ////////////////////////////////////////////////////////////////////////
    // Two entries let software queue two bytes behind the one being sent.
    asp_fifo2 u_tx_buf
    (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (wr_s),
        .out_s (rd_s)
    );

    assign ctrl_wr    = sfr_wr && (sfr_addr == ASP_CTRL_ADDR);
    assign wr_s.valid = sfr_wr && (sfr_addr == ASP_DATA_ADDR);
    assign wr_s.data  = sfr_wdata;
    assign tx_buf_ready = wr_s.ready;

    assign mode9     = st_r.ctrl[ASP_MODE_BIT];
    assign tx_tick   = timer_ovf && st_r.tx_phase;
    assign rd_s.ready = (st_r.tx_st == ASP_IDLE) && tx_tick;
    assign rx_ovf    = timer_clk_tick && (st_r.rx_tmr == ASP_TMR_TOP);
    assign rx_sample = rx_ovf && st_r.rx_phase;
    assign rx_bit9   = mode9 ? st_r.rx_ninth : st_r.sync2;
    assign rx_accept = !st_r.ctrl[ASP_RI_BIT]
                       && (!st_r.ctrl[ASP_MCE_BIT] || rx_bit9);

    assign sfr_rdata      = st_r.rdata;
    assign serial_out_pin = st_r.tx_out;
    assign irq_req = irq_enable
                     && (st_r.ctrl[ASP_TI_BIT] || st_r.ctrl[ASP_RI_BIT]);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.sync1   = serial_in_pin;
        st_nxt.sync2   = st_r.sync1;
        st_nxt.rx_prev = st_r.sync2;
        if (ctrl_wr)
        begin
            st_nxt.ctrl = sfr_wdata;
        end
        if (sfr_rd)
        begin
            if (sfr_addr == ASP_CTRL_ADDR)
            begin
                st_nxt.rdata                = st_r.ctrl;
                st_nxt.rdata[ASP_SPARE_BIT] = 1'b1;
            end
            else if (sfr_addr == ASP_DATA_ADDR)
            begin
                st_nxt.rdata = st_r.rx_latch;
            end
            else
            begin
                st_nxt.rdata = ASP_RDATA_NONE;
            end
        end
        // Transmit side: one bit per second timer overflow.
        if (timer_ovf)
        begin
            st_nxt.tx_phase = ~st_r.tx_phase;
        end
        if (tx_tick)
        begin
            case (st_r.tx_st)
                ASP_IDLE:
                begin
                    if (rd_s.valid)
                    begin
                        st_nxt.tx_sh  = rd_s.data;
                        st_nxt.tx_out = 1'b0;
                        st_nxt.tx_st  = ASP_START;
                    end
                end
                ASP_START:
                begin
                    st_nxt.tx_out = st_r.tx_sh[0];
                    st_nxt.tx_sh  = st_r.tx_sh >> 1;
                    st_nxt.tx_cnt = 4'h0;
                    st_nxt.tx_st  = ASP_DATA;
                end
                ASP_DATA:
                begin
                    if (st_r.tx_cnt == ASP_LAST_DATA)
                    begin
                        if (mode9)
                        begin
                            st_nxt.tx_out = st_r.ctrl[ASP_TB8_BIT];
                            st_nxt.tx_st  = ASP_NINTH;
                        end
                        else
                        begin
                            st_nxt.tx_out = 1'b1;
                            st_nxt.tx_st  = ASP_STOP;
                            st_nxt.ctrl[ASP_TI_BIT] = 1'b1;
                        end
                    end
                    else
                    begin
                        st_nxt.tx_out = st_r.tx_sh[0];
                        st_nxt.tx_sh  = st_r.tx_sh >> 1;
                        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                    end
                end
                ASP_NINTH:
                begin
                    st_nxt.tx_out = 1'b1;
                    st_nxt.tx_st  = ASP_STOP;
                    st_nxt.ctrl[ASP_TI_BIT] = 1'b1;
                end
                default:
                begin
                    st_nxt.tx_st = ASP_IDLE;
                end
            endcase
        end
        // Receive side: the timer copy runs at twice the bit rate, so
        // the first overflow after the reload and every second one after it land mid-bit.
        if (timer_clk_tick)
        begin
            st_nxt.rx_tmr = rx_ovf ? baud_timer_reload_byte
                                   : st_r.rx_tmr + 8'h01;
        end
        if (rx_ovf)
        begin
            st_nxt.rx_phase = ~st_r.rx_phase;
        end
        case (st_r.rx_st)
            ASP_IDLE:
            begin
                if (st_r.ctrl[ASP_REN_BIT] && st_r.rx_prev && !st_r.sync2)
                begin
                    st_nxt.rx_tmr   = baud_timer_reload_byte;
                    st_nxt.rx_phase = 1'b1;
                    st_nxt.rx_st    = ASP_START;
                end
            end
            ASP_START:
            begin
                if (rx_sample)
                begin
                    // A start bit gone high at mid-bit was a glitch.
                    st_nxt.rx_st  = st_r.sync2 ? ASP_IDLE : ASP_DATA;
                    st_nxt.rx_cnt = 4'h0;
                end
            end
            ASP_DATA:
            begin
                if (rx_sample)
                begin
                    st_nxt.rx_sh = {st_r.sync2, st_r.rx_sh[7:1]};
                    st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                    if (st_r.rx_cnt == ASP_LAST_DATA)
                    begin
                        st_nxt.rx_st = mode9 ? ASP_NINTH : ASP_STOP;
                    end
                end
            end
            ASP_NINTH:
            begin
                if (rx_sample)
                begin
                    st_nxt.rx_ninth = st_r.sync2;
                    st_nxt.rx_st    = ASP_STOP;
                end
            end
            default:
            begin
                if (rx_sample)
                begin
                    st_nxt.rx_st = ASP_IDLE;
                    // A busy latch keeps the older byte on overrun.
                    if (rx_accept)
                    begin
                        st_nxt.rx_latch         = st_r.rx_sh;
                        st_nxt.ctrl[ASP_RB8_BIT] = rx_bit9;
                        st_nxt.ctrl[ASP_RI_BIT]  = 1'b1;
                    end
                end
            end
        endcase
        if (!st_r.ctrl[ASP_REN_BIT])
        begin
            st_nxt.rx_st = ASP_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ASP_CORE_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_spare_bit_one: assert property (
        (sfr_rd && sfr_addr == ASP_CTRL_ADDR) |=> sfr_rdata[ASP_SPARE_BIT])
        else $error("Spare control bit read back as zero.");

    a_data_reads_rx: assert property (
        (sfr_rd && sfr_addr == ASP_DATA_ADDR) |=> (sfr_rdata == $past(st_r.rx_latch)))
        else $error("Data read did not return the receive latch.");

    a_ti_at_stop: assert property (
        (st_r.tx_st != ASP_STOP) ##1 (st_r.tx_st == ASP_STOP)
        |-> st_r.ctrl[ASP_TI_BIT] && serial_out_pin)
        else $error("Stop bit began without transmit flag or high line.");

    a_tx_idle_high: assert property (
        (st_r.tx_st == ASP_IDLE) |-> serial_out_pin)
        else $error("Transmit line low while idle.");

    a_ninth_from_tb8: assert property (
        (st_r.tx_st == ASP_DATA) ##1 (st_r.tx_st == ASP_NINTH)
        |-> (serial_out_pin == $past(st_r.ctrl[ASP_TB8_BIT])) && $past(mode9))
        else $error("Ninth bit does not match control bit 3.");

    a_flags_sticky: assert property (
        !ctrl_wr |=> (st_r.ctrl[ASP_RI_BIT] || !$past(st_r.ctrl[ASP_RI_BIT]))
                     && (st_r.ctrl[ASP_TI_BIT] || !$past(st_r.ctrl[ASP_TI_BIT])))
        else $error("Hardware cleared a done flag.");

    a_start_reload: assert property (
        (st_r.rx_st == ASP_IDLE && st_r.ctrl[ASP_REN_BIT]
         && st_r.rx_prev && !st_r.sync2)
        |=> (st_r.rx_st == ASP_START)
            && (st_r.rx_tmr == $past(baud_timer_reload_byte)))
        else $error("Start edge did not reload the receive timer.");

    a_reject_keeps: assert property (
        (st_r.rx_st == ASP_STOP && rx_sample && !rx_accept && !ctrl_wr)
        |=> $stable(st_r.rx_latch) && $stable(st_r.ctrl[ASP_RB8_BIT])
            && !st_r.ctrl[ASP_RI_BIT] == !$past(st_r.ctrl[ASP_RI_BIT]))
        else $error("Rejected character changed the receive state.");

    a_accept_loads: assert property (
        (st_r.rx_st == ASP_STOP && rx_sample && rx_accept && st_r.ctrl[ASP_REN_BIT])
        |=> st_r.ctrl[ASP_RI_BIT] && (st_r.rx_latch == $past(st_r.rx_sh)))
        else $error("Accepted character not loaded with flag.");

    a_ren_off_idle: assert property (
        !st_r.ctrl[ASP_REN_BIT] |=> (st_r.rx_st == ASP_IDLE))
        else $error("Receiver busy while disabled.");

    c_tx_frame: cover property (
        (st_r.tx_st == ASP_STOP) ##1 (st_r.tx_st == ASP_IDLE));
    c_rx_accept: cover property (
        st_r.rx_st == ASP_STOP && rx_sample && rx_accept);
    c_rx_overrun: cover property (
        st_r.rx_st == ASP_STOP && rx_sample && st_r.ctrl[ASP_RI_BIT]);
    c_rx_ninth: cover property (
        st_r.rx_st == ASP_NINTH && rx_sample);
endmodule

// [testbench/asp_far_uart.sv]
/*
 * Behavioural remote UART that faces the serial port across its two pins.
 * Assumes the bench sets nine before each frame and that one bit lasts
 * BIT_CLKS system clocks, matching the timer pattern the bench drives.
 */
module asp_far_uart
#(
    parameter int BIT_CLKS = 8
)
(
    // Clock.
    input  wire logic clk,
    // Serial lines, seen from the far side.
    input  wire logic from_dev,
    output logic      to_dev
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       nine;
    logic [9:0] got_q[$];
    logic [9:0] frame;

    initial
    begin
        to_dev = 1'b1;
        nine   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // In 8-bit frames bit9 is sent as the stop bit, so a bad stop can be made.
    task automatic send(input logic [7:0] data, input logic bit9);
        logic [10:0] bits;
        int          len;
        bits = {1'b1, bit9, data, 1'b0};
        len  = nine ? 11 : 10;
        @(negedge clk);
        for (int i = 0; i < len; i++)
        begin
            to_dev = bits[i];
            repeat (BIT_CLKS) @(negedge clk);
        end
        to_dev = 1'b1;
        repeat (2 * BIT_CLKS) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Samples mid-bit from the falling start edge; stores {stop, ninth, data}.
    always
    begin
        @(negedge from_dev);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < (nine ? 10 : 9); i++)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            frame[i] = from_dev;
        end
        if (!nine)
        begin
            frame = {frame[8], 1'b0, frame[7:0]};
        end
        got_q.push_back(frame);
    end
endmodule

// [testbench/tb.sv]
/*
 * Self-checking bench for the serial port: register tasks, a baud timer
 * that ticks every second clock, and a remote UART model on the pins.
 * Assumes the reload byte 0xFC so both bit timers give sixteen clocks a bit.
 */
`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("[FAIL] %0t got %h exp %h", $time, a, b); \
        end \
    end

module tb
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rst_n, sfr_wr, sfr_rd, timer_ovf, irq_enable, timer_clk_tick;
    logic       irq_req, tx_buf_ready, serial_in_pin, serial_out_pin;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val, reload_byte;
    logic [1:0] tmr_cnt;
    int         mismatches, checked;

    asp_serial_port i_dut (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .sfr_addr               (sfr_addr),
        .sfr_wdata              (sfr_wdata),
        .sfr_wr                 (sfr_wr),
        .sfr_rd                 (sfr_rd),
        .sfr_rdata              (sfr_rdata),
        .tx_buf_ready           (tx_buf_ready),
        .timer_clk_tick         (timer_clk_tick),
        .timer_ovf              (timer_ovf),
        .baud_timer_reload_byte (reload_byte),
        .irq_enable             (irq_enable),
        .irq_req                (irq_req),
        .serial_in_pin          (serial_in_pin),
        .serial_out_pin         (serial_out_pin)
    );

    asp_far_uart #(.BIT_CLKS(16)) i_far (
        .clk      (clk),
        .from_dev (serial_out_pin),
        .to_dev   (serial_in_pin)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Four ticks from 0xFC to overflow, the same as the receive timer copy.
    // The overflow pulse sits on a tick cycle, as an auto-reload timer gives it.
    always @(negedge clk)
    begin
        timer_clk_tick <= ~timer_clk_tick;
        tmr_cnt        <= tmr_cnt + {1'b0, timer_clk_tick};
        timer_ovf      <= !timer_clk_tick && (tmr_cnt == 2'h3);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        rd_val = sfr_rdata;
        `CHK(rd_val, exp)
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A start that never comes would hang the bench, so every wait is bounded.
    task automatic wait_for(input bit frames, input int n);
        int k;
        k = 0;
        while ((frames ? i_far.got_q.size() < n : serial_out_pin !== 1'b0) && k < 3000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000)
        begin
            mismatches++;
            $display("[FAIL] %0t waited %h exp %h", $time, i_far.got_q.size(), n);
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sfr_addr       = 8'h00;
        sfr_wdata      = 8'h00;
        sfr_wr         = 1'b0;
        sfr_rd         = 1'b0;
        irq_enable     = 1'b0;
        tmr_cnt        = 2'h0;
        timer_ovf      = 1'b0;
        timer_clk_tick = 1'b0;
        reload_byte    = 8'hFC;
        mismatches     = 0;
        checked        = 0;
        rst_n          = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        `CHK(serial_out_pin, 1'b1)
        chk_rd(ASP_CTRL_ADDR, 8'h40);
        wr(ASP_CTRL_ADDR, 8'hA0);
        chk_rd(ASP_CTRL_ADDR, 8'hE0);
        chk_rd(8'h97, 8'h00);
        // 8-bit sending with the ninth-bit field clear: a stray ninth bit
        // would then sit where the far end samples the stop bit.
        wr(ASP_CTRL_ADDR, 8'h00);
        wr(ASP_DATA_ADDR, 8'hA5);
        chk_rd(ASP_CTRL_ADDR, 8'h40);
        wait_for(1'b0, 0);
        `CHK(tx_buf_ready, 1'b1)
        wr(ASP_DATA_ADDR, 8'h5C);
        wr(ASP_DATA_ADDR, 8'hC3);
        `CHK(tx_buf_ready, 1'b0)
        wr(ASP_DATA_ADDR, 8'hFF);
        wait_for(1'b1, 3);
        `CHK(i_far.got_q[0], {2'h2, 8'hA5})
        `CHK(i_far.got_q[1], {2'h2, 8'h5C})
        `CHK(i_far.got_q[2], {2'h2, 8'hC3})
        chk_rd(ASP_CTRL_ADDR, 8'h42);
        irq_enable = 1'b1;
        @(negedge clk);
        `CHK(irq_req, 1'b1)
        wr(ASP_CTRL_ADDR, 8'h00);
        `CHK(irq_req, 1'b0)
        // 9-bit sending carries the ninth-bit field.
        i_far.nine = 1'b1;
        wr(ASP_CTRL_ADDR, 8'h88);
        wr(ASP_DATA_ADDR, 8'h3C);
        wait_for(1'b1, 4);
        `CHK(i_far.got_q[3], {2'h3, 8'h3C})
        wr(ASP_CTRL_ADDR, 8'h80);
        wr(ASP_DATA_ADDR, 8'hC3);
        wait_for(1'b1, 5);
        `CHK(i_far.got_q[4], {2'h2, 8'hC3})
        chk_rd(ASP_CTRL_ADDR, 8'hC2);
        // 8-bit reception, overrun, bad stop with checking, disabled receiver.
        i_far.nine = 1'b0;
        wr(ASP_CTRL_ADDR, 8'h10);
        i_far.send(8'h5A, 1'b1);
        chk_rd(ASP_CTRL_ADDR, 8'h55);
        chk_rd(ASP_DATA_ADDR, 8'h5A);
        `CHK(irq_req, 1'b1)
        i_far.send(8'hC3, 1'b1);
        chk_rd(ASP_CTRL_ADDR, 8'h55);
        chk_rd(ASP_DATA_ADDR, 8'h5A);
        wr(ASP_CTRL_ADDR, 8'h30);
        i_far.send(8'h66, 1'b0);
        chk_rd(ASP_CTRL_ADDR, 8'h70);
        chk_rd(ASP_DATA_ADDR, 8'h5A);
        wr(ASP_CTRL_ADDR, 8'h20);
        i_far.send(8'h11, 1'b1);
        chk_rd(ASP_CTRL_ADDR, 8'h60);
        chk_rd(ASP_DATA_ADDR, 8'h5A);
        // 9-bit reception with address filtering on, then off.
        i_far.nine = 1'b1;
        wr(ASP_CTRL_ADDR, 8'hB0);
        i_far.send(8'h22, 1'b0);
        chk_rd(ASP_CTRL_ADDR, 8'hF0);
        i_far.send(8'h33, 1'b1);
        chk_rd(ASP_CTRL_ADDR, 8'hF5);
        chk_rd(ASP_DATA_ADDR, 8'h33);
        wr(ASP_CTRL_ADDR, 8'h90);
        i_far.send(8'h44, 1'b0);
        chk_rd(ASP_CTRL_ADDR, 8'hD1);
        chk_rd(ASP_DATA_ADDR, 8'h44);
        `CHK(i_far.got_q.size(), 5)
        finish_test();
    end
endmodule
